// >>> core/core_status_option_calibration_regs.sv
// Status, option and oscillator trim registers of the small controller core
// Operation
// R1 - Bit 7 marks reset from pin-change wake
// R2 - Bit 5 picks upper or lower program page
// R3 - Timeout flag set on power/clear/sleep, cleared on timeout
// R4 - Powerdown flag set power/clear, cleared by sleep
// R5 - Zero flag follows result equal zero
// R6 - Add: digit carry from low nibble
// R7 - Subtract: digit carry means no nibble borrow
// R8 - Carry on add; no-borrow on subtract
// R9 - Rotates load carry with shifted-out bit
// R10 - Software leaves bit 6, TO and PD alone
// R11 - Option write-only, loaded by option instruction
// R12 - Every reset sets option to all ones
// R13 - Output pins lose wake and pull-up
// R14 - Option bit 7 low enables wake
// R15 - Option bit 6 low enables pull-ups
// R16 - Option bit 5 picks external timer clock
// R17 - Option bit 4 picks falling edge
// R18 - Option bit 3 gives prescaler to watchdog
// R19 - Rate code divides timer and watchdog
// R20 - Trim bits 7:1 signed frequency value
// R21 - Trim bit 0 reads zero, resets ones
// R22 - Software keeps the loaded trim value
// R23 - Flag-updating writes skip Z, DC, C
// R24 - Status and trim mapped; option unaddressable
`timescale 1ns/1ps
module core_status_option_calibration_regs #(
  parameter int PINS = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Soft reset pulse with its cause
  input wire logic soft_reset,
  input wire core_regs_pkg::reset_cause_t reset_cause,
  // Data file access from the core
  input wire logic [4:0] file_addr,
  input wire logic file_wr,
  input wire logic [7:0] file_wdata,
  // ALU result and flag update
  input wire core_regs_pkg::alu_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic [7:0] alu_result,
  // Special instructions
  input wire logic option_load,
  input wire logic [7:0] work_reg,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic watchdog_timeout,
  // Pin direction bits, 1 means input
  input wire logic [PINS-1:0] pin_direction_bits,
  // Register read data
  output logic [7:0] file_rdata,
  // Control outputs
  output logic [9:0] page_base,
  output logic program_page_select,
  output logic [PINS-1:0] wake_enable,
  output logic [PINS-1:0] pullup_enable,
  output logic timer_clock_source_sel,
  output logic timer_edge_sel,
  output logic timer_pin_override,
  output logic prescaler_assign,
  output logic [2:0] prescaler_rate,
  output logic [7:0] timer_tap,
  output logic [7:0] wdt_tap,
  output logic [6:0] osc_trim
);

  // All state of the block
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] option;
    logic [6:0] trim;
    logic [7:0] rdata;
    logic [9:0] page_base;
    logic [PINS-1:0] wake_en;
    logic [PINS-1:0] pull_en;
    logic [7:0] timer_tap;
    logic [7:0] wdt_tap;
  } state_t;

  state_t cur_ff;
  state_t nxt_ff;
  logic [7:0] dec_timer_tap;
  logic [7:0] dec_wdt_tap;

  // Prescaler tap decode from the option register
  prescale_decode #(
    .TAPS(8)
  ) u_decode (
    .rate(cur_ff.option[2:0]),
    .assign_wdt(cur_ff.option[core_regs_pkg::OPT_PSA_BIT]),
    .timer_tap(dec_timer_tap),
    .wdt_tap(dec_wdt_tap)
  );

  // Next-state logic
  always_comb begin
    logic [4:0] nib;
    logic [8:0] wide;
    logic flag_op;
    nib = 5'h00;
    wide = 9'h000;
    flag_op = 1'b0;
    nxt_ff = cur_ff;
    if (soft_reset) begin
      // R12 option all ones
      nxt_ff.option = core_regs_pkg::OPTION_RST;
      nxt_ff.trim = core_regs_pkg::TRIM_RST;
      // R1 wake cause flag
      nxt_ff.status[core_regs_pkg::WAKE_BIT] = (reset_cause == core_regs_pkg::RST_WAKE_CHANGE);
      nxt_ff.status[core_regs_pkg::RSVD_BIT] = 1'b0;
      nxt_ff.status[core_regs_pkg::PAGE_BIT] = 1'b0;
      if (reset_cause == core_regs_pkg::RST_POWERUP) begin
        nxt_ff.status[core_regs_pkg::TO_BIT] = 1'b1;
        nxt_ff.status[core_regs_pkg::PD_BIT] = 1'b1;
      end
      // R3 timeout reset clears flag
      if (reset_cause == core_regs_pkg::RST_WATCHDOG) begin
        nxt_ff.status[core_regs_pkg::TO_BIT] = 1'b0;
      end
    end else begin
      flag_op = (alu_op != core_regs_pkg::ALU_NONE);
      // R24 status and trim writes at fixed addresses
      if (file_wr && file_addr == core_regs_pkg::STATUS_ADDR) begin
        nxt_ff.status[core_regs_pkg::WAKE_BIT] = file_wdata[core_regs_pkg::WAKE_BIT];
        nxt_ff.status[core_regs_pkg::PAGE_BIT] = file_wdata[core_regs_pkg::PAGE_BIT];
        // R23 flag writes suppressed
        if (!flag_op) begin
          nxt_ff.status[2:0] = file_wdata[2:0];
        end
      end
      // R20 trim holds signed value
      if (file_wr && file_addr == core_regs_pkg::TRIM_ADDR) begin
        nxt_ff.trim = file_wdata[7:1];
      end
      // R11 option loaded from working register
      if (option_load) begin
        nxt_ff.option = work_reg;
      end
      // R5 zero flag
      if (alu_op == core_regs_pkg::ALU_LOGIC || alu_op == core_regs_pkg::ALU_ADD
          || alu_op == core_regs_pkg::ALU_SUB) begin
        nxt_ff.status[core_regs_pkg::Z_BIT] = (alu_result == 8'h00);
      end
      // R6 add digit carry and R8 add carry
      if (alu_op == core_regs_pkg::ALU_ADD) begin
        nib = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
        wide = {1'b0, alu_a} + {1'b0, alu_b};
        nxt_ff.status[core_regs_pkg::DC_BIT] = nib[4];
        nxt_ff.status[core_regs_pkg::C_BIT] = wide[8];
      end
      // R7 subtract digit no-borrow and R8 subtract no-borrow
      if (alu_op == core_regs_pkg::ALU_SUB) begin
        nxt_ff.status[core_regs_pkg::DC_BIT] = (alu_a[3:0] >= alu_b[3:0]);
        nxt_ff.status[core_regs_pkg::C_BIT] = (alu_a >= alu_b);
      end
      // R9 rotate through carry
      if (alu_op == core_regs_pkg::ALU_RRF) begin
        nxt_ff.status[core_regs_pkg::C_BIT] = alu_a[0];
      end
      if (alu_op == core_regs_pkg::ALU_RLF) begin
        nxt_ff.status[core_regs_pkg::C_BIT] = alu_a[7];
      end
      // R3 R4 watchdog clear and sleep
      if (watchdog_clear_instr) begin
        nxt_ff.status[core_regs_pkg::TO_BIT] = 1'b1;
        nxt_ff.status[core_regs_pkg::PD_BIT] = 1'b1;
      end
      if (sleep_instr) begin
        nxt_ff.status[core_regs_pkg::TO_BIT] = 1'b1;
        nxt_ff.status[core_regs_pkg::PD_BIT] = 1'b0;
      end
      // R3 timeout clears flag
      if (watchdog_timeout) begin
        nxt_ff.status[core_regs_pkg::TO_BIT] = 1'b0;
      end
    end
    // R24 read mux, option has no address
    unique case (file_addr)
      core_regs_pkg::STATUS_ADDR: nxt_ff.rdata = nxt_ff.status & 8'hbf;
      // R21 trim bit 0 reads zero
      core_regs_pkg::TRIM_ADDR: nxt_ff.rdata = {nxt_ff.trim, 1'b0};
      default: nxt_ff.rdata = 8'h00;
    endcase
    // R2 page base
    nxt_ff.page_base = nxt_ff.status[core_regs_pkg::PAGE_BIT] ? core_regs_pkg::PAGE1_BASE
                                                            : core_regs_pkg::PAGE0_BASE;
    // R13 R14 R15 outputs lose wake and pull-up
    nxt_ff.wake_en = pin_direction_bits & {PINS{!nxt_ff.option[core_regs_pkg::OPT_WAKE_BIT]}};
    nxt_ff.pull_en = pin_direction_bits & {PINS{!nxt_ff.option[core_regs_pkg::OPT_PULL_BIT]}};
    // R18 R19 prescaler taps
    nxt_ff.timer_tap = dec_timer_tap;
    nxt_ff.wdt_tap = dec_wdt_tap;
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff <= '{status: core_regs_pkg::STATUS_POR, option: core_regs_pkg::OPTION_RST,
                  trim: core_regs_pkg::TRIM_RST, rdata: 8'h00, page_base: core_regs_pkg::PAGE0_BASE,
                  wake_en: '0, pull_en: '0, timer_tap: 8'h00, wdt_tap: 8'h80};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs straight from flops
  assign file_rdata = cur_ff.rdata;
  assign page_base = cur_ff.page_base;
  assign program_page_select = cur_ff.status[core_regs_pkg::PAGE_BIT];
  assign wake_enable = cur_ff.wake_en;
  assign pullup_enable = cur_ff.pull_en;
  // R16 R17 timer source and edge
  assign timer_clock_source_sel = cur_ff.option[core_regs_pkg::OPT_CS_BIT];
  assign timer_pin_override = cur_ff.option[core_regs_pkg::OPT_CS_BIT];
  assign timer_edge_sel = cur_ff.option[core_regs_pkg::OPT_EDGE_BIT];
  assign prescaler_assign = cur_ff.option[core_regs_pkg::OPT_PSA_BIT];
  assign prescaler_rate = cur_ff.option[2:0];
  assign timer_tap = cur_ff.timer_tap;
  assign wdt_tap = cur_ff.wdt_tap;
  assign osc_trim = cur_ff.trim;

endmodule : core_status_option_calibration_regs

// >>> core/core_regs_pkg.sv
// Package with status and trim offsets, status and option field positions, and reset values of the core status, option and trim registers
package core_regs_pkg;

  // Data file addresses
  localparam logic [4:0] STATUS_ADDR = 5'h03;
  localparam logic [4:0] TRIM_ADDR = 5'h05;

  // Status field positions
  localparam int WAKE_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int PAGE_BIT = 5;
  localparam int TO_BIT = 4;
  localparam int PD_BIT = 3;
  localparam int Z_BIT = 2;
  localparam int DC_BIT = 1;
  localparam int C_BIT = 0;

  // Option field positions
  localparam int OPT_WAKE_BIT = 7;
  localparam int OPT_PULL_BIT = 6;
  localparam int OPT_CS_BIT = 5;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_PSA_BIT = 3;
  localparam int OPT_RATE_LSB = 0;

  // Reset values
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [6:0] TRIM_RST = 7'h7f;
  localparam logic [7:0] STATUS_POR = 8'h18;

  // Program page bases
  localparam logic [9:0] PAGE0_BASE = 10'h000;
  localparam logic [9:0] PAGE1_BASE = 10'h200;

  // ALU operation codes presented by the core
  typedef enum logic [2:0] {
    ALU_NONE,
    ALU_LOGIC,
    ALU_ADD,
    ALU_SUB,
    ALU_RRF,
    ALU_RLF
  } alu_op_t;

  // Reset causes presented with a reset pulse
  typedef enum logic [1:0] {
    RST_POWERUP,
    RST_PIN,
    RST_WATCHDOG,
    RST_WAKE_CHANGE
  } reset_cause_t;

endpackage : core_regs_pkg

// >>> core/prescale_decode.sv
// Decoder from the prescaler rate code to per-bit taps for timer and watchdog
`timescale 1ns/1ps
module prescale_decode #(
  parameter int TAPS = 8
) (
  // Rate and assignment
  input wire logic [2:0] rate,
  input wire logic assign_wdt,
  // One-hot taps
  output logic [TAPS-1:0] timer_tap,
  output logic [TAPS-1:0] wdt_tap
);

  // Timer divides by 2^(rate+1), watchdog by 2^rate, each only when assigned
  genvar i;
  generate
    for (i = 0; i < TAPS; i++) begin : g_tap
      assign timer_tap[i] = !assign_wdt && (rate == 3'(i));
      assign wdt_tap[i] = assign_wdt && (rate == 3'(i));
    end
  endgenerate

endmodule : prescale_decode

// >>> verif/core_regs_monitor.sv
// Checker of status, option and trim behaviour at the register block ports
`timescale 1ns/1ps
module core_regs_monitor #(
  parameter int PINS = 6
) (
  // Clock, reset and requests
  input wire logic core_clk, rstn, soft_reset, option_load, sleep_instr, watchdog_timeout,
  input wire logic [4:0] file_addr,
  input wire logic [PINS-1:0] pin_direction_bits,
  input wire logic [7:0] work_reg,
  // Observed outputs
  input wire logic [7:0] file_rdata, timer_tap, wdt_tap,
  input wire logic [PINS-1:0] wake_enable, pullup_enable,
  input wire logic program_page_select, timer_clock_source_sel, timer_edge_sel, prescaler_assign,
  input wire logic [9:0] page_base,
  input wire logic [2:0] prescaler_rate,
  input wire logic [6:0] osc_trim
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  AST_OPT_LOAD: assert property (option_load && !soft_reset |=>
    {timer_clock_source_sel, timer_edge_sel, prescaler_assign, prescaler_rate} == $past(work_reg[5:0]))
    else $error("option load lost");
  AST_OPT_RESET: assert property (soft_reset |=>
    {prescaler_assign, prescaler_rate, osc_trim, program_page_select} == 12'hffe) else $error("soft reset values");
  AST_PAGE: assert property (page_base == (program_page_select ? 10'h200 : 10'h000))
    else $error("page base wrong");
  AST_PIN_GATE: assert property (1'b1 |=> ((wake_enable | pullup_enable) & ~$past(pin_direction_bits)) == '0)
    else $error("output pin kept wake or pull-up");
  AST_TAPS: assert property (1'b1 |=> {wdt_tap, timer_tap} ==
    ($past(prescaler_assign) ? 16'h0100 : 16'h0001) << $past(prescaler_rate)) else $error("tap wrong");
  AST_SLEEP: assert property (sleep_instr && !soft_reset && !watchdog_timeout && file_addr == 5'h03
    |=> file_rdata[4:3] == 2'b10) else $error("sleep flags wrong");
  AST_TIMEOUT: assert property (watchdog_timeout && !soft_reset && file_addr == 5'h03 |=> !file_rdata[4])
    else $error("timeout flag kept");
  AST_TRIM_READ: assert property (file_addr == 5'h05 |=> file_rdata == {osc_trim, 1'b0})
    else $error("trim read wrong");
endmodule : core_regs_monitor
bind core_status_option_calibration_regs core_regs_monitor #(.PINS(PINS)) u_mon (.*);

// >>> verif/core_alu_model.sv
// Behavioural core ALU that forms the result the zero flag looks at
`timescale 1ns/1ps
module core_alu_model (
  // Operation and operands
  input wire core_regs_pkg::alu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  // Operation result
  output logic [7:0] result
);
  // Result per operation; rotates leave the zero flag alone, so their value is loose
  always_comb begin
    case (op)
      core_regs_pkg::ALU_ADD: result = a + b;
      core_regs_pkg::ALU_SUB: result = a - b;
      core_regs_pkg::ALU_LOGIC: result = a ^ b;
      default: result = {a[6:0], a[7]};
    endcase
  end
endmodule : core_alu_model

// >>> verif/core_status_option_calibration_regs_tb.sv
// Self-checking bench for the status, option and trim registers
`timescale 1ns/1ps
module core_status_option_calibration_regs_tb;
  logic core_clk, rstn, soft_reset, file_wr, option_load, watchdog_clear_instr, sleep_instr, watchdog_timeout;
  logic program_page_select, timer_clock_source_sel, timer_edge_sel, timer_pin_override, prescaler_assign;
  core_regs_pkg::reset_cause_t reset_cause;
  core_regs_pkg::alu_op_t alu_op;
  logic [4:0] file_addr;
  logic [7:0] file_wdata, alu_a, alu_b, alu_result, work_reg, file_rdata, timer_tap, wdt_tap;
  logic [5:0] pin_direction_bits, wake_enable, pullup_enable;
  logic [9:0] page_base;
  logic [6:0] osc_trim;
  logic [2:0] prescaler_rate, m, e;
  logic [15:0] r = 16'h8688;
  logic [2:0] ev [5] = '{3'b100, 3'b010, 3'b001, 3'b101, 3'b010};
  logic [1:0] ex [5] = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b11};
  int num_errors = 0;
  int checks = 0;
  // Design and core ALU model
  core_status_option_calibration_regs #(.PINS(6)) uut (.*);
  core_alu_model u_alu (.op(alu_op), .a(alu_a), .b(alu_b), .result(alu_result));
  // Next pseudo-random state
  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  // Expected zero, digit-carry and carry flags
  function automatic logic [2:0] fl(core_regs_pkg::alu_op_t o, logic [7:0] a, logic [7:0] b);
    logic sb;
    logic [8:0] s;
    logic [4:0] n;
    sb = (o == core_regs_pkg::ALU_SUB);
    s = {1'b0, a} + (sb ? {1'b0, ~b} + 9'h001 : {1'b0, b});
    n = {1'b0, a[3:0]} + (sb ? {1'b0, ~b[3:0]} + 5'h01 : {1'b0, b[3:0]});
    if (o == core_regs_pkg::ALU_LOGIC) return {(a ^ b) == 8'h00, 2'h0};
    if (o > core_regs_pkg::ALU_SUB) return {2'h0, (o == core_regs_pkg::ALU_RRF) ? a[0] : a[7]};
    return {s[7:0] == 8'h00, n[4], s[8]};
  endfunction : fl
  // Compare, count and report
  task automatic chk(string nm, logic [15:0] x, logic [15:0] g);
    checks++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // One clock edge, then drop the single-cycle requests
  task automatic tick();
    @(negedge core_clk);
    {soft_reset, file_wr, option_load, watchdog_clear_instr, sleep_instr, watchdog_timeout} = '0;
    alu_op = core_regs_pkg::ALU_NONE;
  endtask : tick
  // Counts and verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Hang guard
  initial begin
    #5000;
    num_errors++;
    complete_run();
  end
  // Test sequence
  initial begin
    rstn = 1'b0;
    {soft_reset, file_wr, option_load, watchdog_clear_instr, sleep_instr, watchdog_timeout} = '0;
    {file_wdata, alu_a, alu_b, work_reg} = '0;
    alu_op = core_regs_pkg::ALU_NONE;
    reset_cause = core_regs_pkg::RST_POWERUP;
    pin_direction_bits = 6'h3f;
    file_addr = 5'h03;
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    tick();
    chk("por", 16'h1807, {file_rdata, 5'h00, prescaler_rate});
    file_addr = 5'h05;
    tick();
    chk("trim_por", 16'h00fe, {8'h00, file_rdata});
    file_addr = 5'h03;
    file_wr = 1'b1;
    file_wdata = 8'hff;
    tick();
    chk("status_ff", 16'hbf80, {file_rdata, page_base[9:2]});
    file_wr = 1'b1;
    file_wdata = 8'h00;
    tick();
    chk("status_00", 16'h1800, {file_rdata, page_base[9:2]});
    for (int i = 0; i < 5; i++) begin
      {sleep_instr, watchdog_clear_instr, watchdog_timeout} = ev[i];
      tick();
      chk("to_pd", {14'h0, ex[i]}, {14'h0, file_rdata[4:3]});
    end
    $display("reset flag test done");
    for (int i = 0; i < 40; i++) begin
      r = nx(r);
      alu_op = core_regs_pkg::alu_op_t'(r[2:0] % 3'h5 + 3'h1);
      alu_a = r[15:8];
      alu_b = (i == 0) ? r[15:8] : r[7:0];
      file_wr = 1'b1;
      file_wdata = r[7:0];
      m = (alu_op > core_regs_pkg::ALU_SUB) ? 3'b001 : (alu_op == core_regs_pkg::ALU_LOGIC) ? 3'b100 : 3'b111;
      e = fl(alu_op, alu_a, alu_b);
      tick();
      chk("flags", {13'h0, e & m}, {13'h0, file_rdata[2:0] & m});
    end
    $display("alu flag test done");
    for (int i = 0; i < 16; i++) begin
      r = nx(r);
      work_reg = {r[15:11], i[2:0]};
      pin_direction_bits = r[5:0];
      option_load = 1'b1;
      tick();
      tick();
      chk("opt", {10'h0, work_reg[5:0]}, {10'h0, timer_pin_override, timer_edge_sel, prescaler_assign, prescaler_rate});
      chk("tcs", {15'h0, work_reg[5]}, {15'h0, timer_clock_source_sel});
      chk("pins", {4'h0, r[5:0] & {6{~work_reg[7]}}, r[5:0] & {6{~work_reg[6]}}}, {4'h0, wake_enable, pullup_enable});
      chk("taps", (work_reg[3] ? 16'h0100 : 16'h0001) << i[2:0], {wdt_tap, timer_tap});
    end
    file_addr = 5'h00;
    tick();
    chk("unmapped", 16'h0000, {8'h00, file_rdata});
    $display("option test done");
    for (int i = 0; i < 4; i++) begin
      r = nx(r);
      file_addr = 5'h05;
      file_wr = 1'b1;
      file_wdata = r[7:0];
      option_load = 1'b1;
      work_reg = 8'h00;
      tick();
      chk("trim", {8'h00, r[7:1], 1'b0}, {8'h00, file_rdata});
      file_addr = 5'h03;
      file_wr = 1'b1;
      file_wdata = 8'h20;
      watchdog_clear_instr = 1'b1;
      tick();
      soft_reset = 1'b1;
      reset_cause = core_regs_pkg::reset_cause_t'(i[1:0]);
      tick();
      tick();
      chk("soft", {1'b0, i == 3, 2'b00, i != 2, 1'b1, 7'h7f, 3'h7}, {1'b0, file_rdata[7:3], osc_trim, prescaler_rate});
    end
    $display("soft reset test done");
    complete_run();
  end
endmodule : core_status_option_calibration_regs_tb
